/* File: pcmc_pkg.sv */
/*
   Constants for the clock-mode control block: register address, field
   positions, reset values and lock-timer figures.
   Assumes one clock (the reference input, 100 MHz) and a plain register port.

*/
package pcmc_pkg;
   localparam int          DATA_W        = 16;
   localparam int          ADDR_W        = 16;
   localparam logic [15:0] CLKMODE_ADDR  = 16'h0058;
   localparam int          MUL_HI        = 15;
   localparam int          MUL_LO        = 12;
   localparam int          FRAC_BIT      = 11;
   localparam int          CNT_HI        = 10;
   localparam int          CNT_LO        = 3;
   localparam int          FORCE_BIT     = 2;
   localparam int          MODE_BIT      = 1;
   localparam int          STATUS_BIT    = 0;
   localparam logic [3:0]  MUL_RESET     = 4'hF;
   localparam logic        FRAC_RESET    = 1'b0;
   localparam logic [7:0]  CNT_RESET     = 8'h00;
   localparam logic        FORCE_RESET   = 1'b0;
   localparam logic        MODE_RESET    = 1'b1;
   localparam logic        STATUS_RESET  = 1'b1;
   localparam logic [3:0]  BYPASS_CODE   = 4'hF;
   localparam int          PRESCALE_DIV  = 16;
   localparam logic [3:0]  PRESCALE_LAST = 4'hF;
   // Ratio is reported in quarters: 4 means times one
   localparam int          RATIO_W       = 7;
   localparam logic [6:0]  RATIO_HALF    = 7'h02;
   localparam logic [6:0]  RATIO_QUARTER = 7'h01;
   localparam logic [6:0]  RATIO_ONE     = 7'h04;
   // Lock timer and divider-path states
   typedef enum logic [1:0] {
      PCMC_DIV  = 2'b00,
      PCMC_LOCK = 2'b01,
      PCMC_PLL  = 2'b10
   } pcmc_state_type;
endpackage

/* File: pcmc_ratio.sv */
/*
   Combinational ratio decoder: maps mode, fraction select and multiplier
   code to the clock ratio in quarters.
   Assumes the caller registers the result.
*/
`timescale 1ns/100ps
module pcmc_ratio
   import pcmc_pkg::*;
(
   // Configuration
   input  wire logic               modeSel,
   input  wire logic               fracSel,
   input  wire logic [3:0]         mulCode,
   // Result in quarters
   output logic      [RATIO_W-1:0] ratioQ
);
   // Table decode of the output ratio
   always_comb
   begin
      ratioQ = RATIO_ONE;
      if (!modeSel)
      begin
         // Fraction select ignored here
         ratioQ = (mulCode == BYPASS_CODE) ? RATIO_QUARTER
                                           : RATIO_HALF;
      end
      else if (!fracSel)
      begin
         if (mulCode == BYPASS_CODE)
            ratioQ = RATIO_ONE;
         else
            ratioQ = RATIO_W'({mulCode + 5'h01, 2'b00});
      end
      else if (!mulCode[0])
      begin
         // (code+1)/2 in quarters is 2*(code+1)
         ratioQ = RATIO_W'({mulCode + 5'h01, 1'b0});
      end
      else
      begin
         // code/4 in quarters is the code itself
         ratioQ = RATIO_W'(mulCode);
      end
   end
endmodule // pcmc_ratio

/* File: pll_clock_mode_control.sv */
/*
   Clock-mode control: the clock mode register, the divide-by-16
   prescaler, the lock down-counter and the clock source selection.
   Assumes it runs on the reference input clock and that the register
   master holds the read address steady only for the strobe cycle.
*/
`timescale 1ns/100ps
module pll_clock_mode_control
   import pcmc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               clkEn,
   // Register port
   input  wire logic [ADDR_W-1:0]  regAddr,
   input  wire logic [DATA_W-1:0]  regWrData,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   input  wire logic               subsysSel,
   output logic      [DATA_W-1:0]  regRdData,
   // Clock generator controls
   output logic                    vcoEnable,
   output logic                    corePllSelect,
   output logic      [RATIO_W-1:0] clockRatio,
   output logic                    lockBusy
);
   // Register fields
   logic [3:0]      multiplierCode;       // Multiplier code
   logic            fractionSelect;       // Integer/fractional select
   logic [7:0]      lockCountPreset;      // Lock count preset
   logic            vcoForceOn;           // VCO force-on
   logic            modeSelect;           // PLL/divider request
   logic            activeModeFlag;       // Active clocking mode
   logic [3:0]      next_multiplierCode;
   logic            next_fractionSelect;
   logic [7:0]      next_lockCountPreset;
   logic            next_vcoForceOn;
   logic            next_modeSelect;
   // Lock timer state
   pcmc_state_type  state;
   pcmc_state_type  next_state;
   logic [3:0]      prescale;             // Divide-by-16 prescaler
   logic [3:0]      next_prescale;
   logic [7:0]      lockCount;            // Lock down-counter
   logic [7:0]      next_lockCount;
   // Outputs held in flip-flops
   logic [DATA_W-1:0]  next_regRdData;
   logic [RATIO_W-1:0] next_clockRatio;
   logic [RATIO_W-1:0] decodedRatio;
   logic [RATIO_W-1:0] divRatio;
   logic               next_vcoEnable;
   // Access qualifiers
   logic            hit;
   logic            wrHit;
   logic            rdHit;

   // Only subsystem A (subsysSel low) decodes this address
   assign hit   = (regAddr == CLKMODE_ADDR) && !subsysSel;
   assign wrHit = regWrite && hit;
   assign rdHit = regRead && hit;

   // Ratio while in PLL mode follows the programmed fields
   pcmc_ratio u_ratio
   (
      .modeSel (modeSelect),
      .fracSel (fractionSelect),
      .mulCode (multiplierCode),
      .ratioQ  (decodedRatio)
   );

   // Divider ratio used while the core still runs from the divider
   pcmc_ratio u_div_ratio
   (
      .modeSel (1'b0),
      .fracSel (1'b0),
      .mulCode (multiplierCode),
      .ratioQ  (divRatio)
   );

   // Register next values; status bit is not writable directly
   always_comb
   begin
      next_multiplierCode  = multiplierCode;
      next_fractionSelect  = fractionSelect;
      next_lockCountPreset = lockCountPreset;
      next_vcoForceOn      = vcoForceOn;
      next_modeSelect      = modeSelect;
      if (wrHit)
      begin
         next_multiplierCode  = regWrData[MUL_HI:MUL_LO];
         next_fractionSelect  = regWrData[FRAC_BIT];
         next_lockCountPreset = regWrData[CNT_HI:CNT_LO];
         next_vcoForceOn      = regWrData[FORCE_BIT];
         next_modeSelect      = regWrData[MODE_BIT];
         // regWrData[STATUS_BIT] is dropped on purpose
      end
   end

   // Lock timer: prescaler and down-counter
   always_comb
   begin
      next_state     = state;
      next_prescale  = prescale;
      next_lockCount = lockCount;
      case (state)
         PCMC_DIV:
         begin
            if (modeSelect)
            begin
               // Divider-to-PLL switch loads the preset
               next_lockCount = lockCountPreset;
               next_prescale  = 4'h0;
               next_state     = PCMC_LOCK;
            end
         end
         PCMC_LOCK:
         begin
            if (!modeSelect)
               next_state = PCMC_DIV;
            else if (lockCount == 8'h00)
               next_state = PCMC_PLL;
            else
            begin
               next_prescale = prescale + 4'h1;
               if (prescale == PRESCALE_LAST)
                  next_lockCount = lockCount - 8'h01;
            end
         end
         PCMC_PLL:
         begin
            // Dropping the request returns to divider at once
            if (!modeSelect)
               next_state = PCMC_DIV;
         end
         default:
            next_state = PCMC_DIV;
      endcase
   end

   // Outputs: clock source, ratio, VCO and read data
   always_comb
   begin
      // Core follows the divider until the timer has expired
      corePllSelect = (state == PCMC_PLL);
      activeModeFlag = corePllSelect;
      lockBusy      = (state == PCMC_LOCK);
      // Fraction select only matters once in PLL mode; the divider ratio still checks the multiplier code for 15
      next_clockRatio = corePllSelect ? decodedRatio : divRatio;
      next_vcoEnable  = vcoForceOn || modeSelect;
      next_regRdData  = '0;
      if (rdHit)
      begin
         next_regRdData[MUL_HI:MUL_LO] = multiplierCode;
         next_regRdData[FRAC_BIT]      = fractionSelect;
         next_regRdData[CNT_HI:CNT_LO] = lockCountPreset;
         next_regRdData[FORCE_BIT]     = vcoForceOn;
         next_regRdData[MODE_BIT]      = modeSelect;
         next_regRdData[STATUS_BIT]    = activeModeFlag;
      end
   end

   // Registers, frozen while the clock enable is low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Bypass at reset: PLL mode, integer, code 15
         multiplierCode  <= MUL_RESET;
         fractionSelect  <= FRAC_RESET;
         lockCountPreset <= CNT_RESET;
         vcoForceOn      <= FORCE_RESET;
         modeSelect      <= MODE_RESET;
         state           <= PCMC_PLL;
         prescale        <= 4'h0;
         lockCount       <= 8'h00;
         regRdData       <= '0;
         clockRatio      <= RATIO_ONE;
         vcoEnable       <= 1'b1;
      end
      else if (clkEn)
      begin
         multiplierCode  <= next_multiplierCode;
         fractionSelect  <= next_fractionSelect;
         lockCountPreset <= next_lockCountPreset;
         vcoForceOn      <= next_vcoForceOn;
         modeSelect      <= next_modeSelect;
         state           <= next_state;
         prescale        <= next_prescale;
         lockCount       <= next_lockCount;
         regRdData       <= next_regRdData;
         clockRatio      <= next_clockRatio;
         vcoEnable       <= next_vcoEnable;
      end
   end
endmodule // pll_clock_mode_control

/* File: pcmc_assertions.sv */
/* Checker for the clock-mode block: read port, VCO enable, lock timing,
   divider ratio. Sees only the block's ports; bound by the bench. */
`timescale 1ns/100ps
module pcmc_assertions
   import pcmc_pkg::*;
(
   // Clock and control
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               clkEn,
   // Register port
   input wire logic [ADDR_W-1:0]  regAddr,
   input wire logic [DATA_W-1:0]  regWrData,
   input wire logic               regWrite,
   input wire logic               regRead,
   input wire logic               subsysSel,
   input wire logic [DATA_W-1:0]  regRdData,
   // Clock generator controls
   input wire logic               vcoEnable,
   input wire logic               corePllSelect,
   input wire logic [RATIO_W-1:0] clockRatio,
   input wire logic               lockBusy
);
   logic        acc;      // Access the block accepts
   logic [3:0]  mulM;     // Shadow of the multiplier code
   logic [7:0]  cntM;     // Shadow of the lock preset
   logic [7:0]  lockPre;  // Preset frozen while the timer runs
   logic [11:0] busyCnt;  // Edges spent with the timer running
   assign acc = clkEn && regAddr == CLKMODE_ADDR && !subsysSel;
   // Shadows follow accepted writes only, so refusals stay invisible
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         mulM    <= MUL_RESET;
         cntM    <= CNT_RESET;
         lockPre <= 8'h00;
         busyCnt <= 12'h000;
      end
      else if (clkEn)
      begin
         if (acc && regWrite)
         begin
            mulM <= regWrData[MUL_HI:MUL_LO];
            cntM <= regWrData[CNT_HI:CNT_LO];
         end
         busyCnt <= lockBusy ? busyCnt + 12'h001 : 12'h000;
         if (!lockBusy)
            lockPre <= cntM;
      end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sWrite;
      acc && regWrite;
   endsequence
   sequence sLockReq;
      sWrite ##0 (regWrData[MODE_BIT] && !corePllSelect && !lockBusy);
   endsequence
   a_vco_follow: assert property (sWrite ##1 (clkEn && !regWrite) |=>
      vcoEnable == ($past(regWrData[FORCE_BIT], 2)
                  | $past(regWrData[MODE_BIT], 2)))
      else $error("VCO enable does not follow force-on and mode");
   a_read_idle: assert property (clkEn && !(acc && regRead) |=>
      regRdData == 16'h0000) else $error("read data outside a read");
   a_read_status: assert property (acc && regRead |=>
      regRdData[STATUS_BIT] == $past(corePllSelect))
      else $error("status bit differs from the clock source");
   a_busy_div: assert property (lockBusy |-> !corePllSelect)
      else $error("core on PLL while the lock timer runs");
   a_pll_via_lock: assert property ($rose(corePllSelect) |->
      $past(lockBusy)) else $error("PLL taken without a lock period");
   a_lock_start: assert property (sLockReq ##1 clkEn |=> lockBusy)
      else $error("lock timer did not start");
   a_lock_len: assert property ($fell(lockBusy) && corePllSelect |->
      busyCnt == {lockPre, 4'h0} + 12'h001)
      else $error("lock period length wrong");
   a_div_ratio: assert property (clkEn && !corePllSelect |=>
      clockRatio == (($past(mulM) == BYPASS_CODE) ? RATIO_QUARTER
                                                  : RATIO_HALF))
      else $error("divider ratio wrong");
endmodule // pcmc_assertions

/* File: pll_clock_mode_control_tb.sv */
/* Bench for the clock-mode block: reset value, refusals, every ratio
   code and the lock delay. Assumes one 100 MHz clock. */
`timescale 1ns/100ps
module pll_clock_mode_control_tb
   import pcmc_pkg::*;
;
   logic               clk, rst_n, clkEn, regWrite, regRead, subsysSel;
   logic [ADDR_W-1:0]  regAddr;
   logic [DATA_W-1:0]  regWrData, regRdData, rd; // rd: last read result
   logic               vcoEnable, corePllSelect, lockBusy, frac, vcoOn;
   logic [RATIO_W-1:0] clockRatio;
   logic [3:0]         code;
   logic [7:0]         pre;
   int                 num_errors, n_checks, n;
   pll_clock_mode_control u_pll_clock_mode_control (.clk(clk),
      .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .subsysSel(subsysSel), .regRdData(regRdData), .vcoEnable(vcoEnable),
      .corePllSelect(corePllSelect), .clockRatio(clockRatio),
      .lockBusy(lockBusy));
   always #5 clk = ~clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d,
                     input logic s);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      subsysSel <= s;
      regWrite  <= 1'b1;
      @(posedge clk);
      regWrite  <= 1'b0;
      subsysSel <= 1'b0;
   endtask
   // Data is taken in the one cycle where it stands
   task automatic rdt(input logic [15:0] a, input logic s);
      @(posedge clk);
      regAddr   <= a;
      subsysSel <= s;
      regRead   <= 1'b1;
      @(posedge clk);
      regRead   <= 1'b0;
      subsysSel <= 1'b0;
      #1 rd = regRdData;
   endtask
   // Expected ratio in quarters
   function automatic logic [6:0] ratioExp(input logic m, input logic f,
                                           input logic [3:0] c);
      if (!m)
         return (c == 4'hF) ? 7'h01 : 7'h02;
      if (!f)
         return (c == 4'hF) ? 7'h04 : {1'b0, c, 2'b00} + 7'h04;
      return c[0] ? {3'b000, c} : {2'b00, c, 1'b0} + 7'h02;
   endfunction
   task automatic final_report;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard, far beyond the longest lock sequence
   initial
   begin
      #200000;
      num_errors++;
      final_report();
   end
   initial
   begin
      {clk, rst_n, regWrite, regRead, subsysSel} = 5'h00;
      {clkEn, regAddr, regWrData} = {1'b1, 32'h0000_0000};
      {num_errors, n_checks} = {32'h0, 32'h0};
      void'($urandom(67));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rdt(CLKMODE_ADDR, 1'b0);
      chk(rd, 16'hF003);
      chk({9'h000, clockRatio}, {9'h000, RATIO_ONE});
      wr(16'h0059, 16'h0000, 1'b0);
      wr(CLKMODE_ADDR, 16'h0000, 1'b1);
      rdt(CLKMODE_ADDR, 1'b0);
      chk(rd, 16'hF003);
      rdt(CLKMODE_ADDR, 1'b1);
      chk(rd, 16'h0000);
      // All codes with both fraction settings, then one preset of 255 and random presets up to 7
      for (int i = 0; i < 40; i++)
      begin
         {frac, code} = i[4:0];
         vcoOn = 1'($urandom);
         // Preset plays software's lockup-time choice
         pre = (i < 32) ? 8'h00 : (i == 32) ? 8'hFF : 8'($urandom % 8);
         wr(CLKMODE_ADDR, {code, frac, pre, vcoOn, 2'b00}, 1'b0);
         repeat (3) @(posedge clk);
         #1 chk({15'h0, vcoEnable}, {15'h0, vcoOn});
         chk({9'h000, clockRatio}, {9'h000, ratioExp(0, frac, code)});
         rdt(CLKMODE_ADDR, 1'b0);
         chk({15'h0, rd[0]}, 16'h0000);
         wr(CLKMODE_ADDR, {code, frac, pre, vcoOn, 2'b10}, 1'b0);
         n = 0;
         do
         begin
            @(posedge clk);
            #1 n++;
         end
         while (!corePllSelect && n < 5000);
         chk(16'(n), 16'(2 + 16 * pre));
         @(posedge clk);
         #1 chk({9'h000, clockRatio}, {9'h000, ratioExp(1, frac, code)});
         rdt(CLKMODE_ADDR, 1'b0);
         chk(rd, {code, frac, pre, vcoOn, 2'b11});
      end
      final_report();
   end
endmodule // pll_clock_mode_control_tb
bind pll_clock_mode_control pcmc_assertions u_pcmc_assertions (.clk(clk),
   .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .subsysSel(subsysSel),
   .regRdData(regRdData), .vcoEnable(vcoEnable),
   .corePllSelect(corePllSelect), .clockRatio(clockRatio),
   .lockBusy(lockBusy));
